// ===== rtl/psa_pcm_slot_access.sv
// PCM highway slot assignment per channel with controller sample insert and capture
//
// Overview of operation
// - Disabled transmit slot leaves output undriven
// - Enabled transmit slot drives channel sample
// - Transmit slot number spans zero to 127
// - Linear transmit: high byte, then next slot
// - Disabled receive slot input is ignored
// - Enabled receive slot captured and routed
// - Receive slot 0-127, linear uses next
// - Two-byte insertion buffer, low then high
// - Insert write clears write-caused interrupt
// - Companded uses low byte, linear both
// - Read-only two-byte capture buffer
// - Capture read clears read-caused interrupt
// - Write access: interrupt and wait flag per frame
// - Missed write reuses value, sets flag
// - Missed read overwrites, sets flag
// - Ready flag clears after low-high reads
module psa_pcm_slot_access (
	// System clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	// Register port
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output logic      [7:0]        reg_rdata,
	// Configuration bits held outside this map
	input  wire logic [7:0]        tx_slot_ch0,
	input  wire logic              linear_mode,
	input  wire psa_pkg::psa_access_s access_cfg,
	// Codec sample paths
	input  wire psa_pkg::psa_samples_t tx_sample,
	output psa_pkg::psa_samples_t  rx_sample,
	output logic      [3:0]        rx_valid,
	// Access status and interrupt
	output psa_pkg::psa_status_s   access_status,
	output logic                   sample_access_interrupt,
	// PCM highway
	input  wire logic              pcm_clk,
	input  wire logic              pcm_fs,
	input  wire logic              pcm_serial_input,
	output logic                   pcm_serial_output,
	output logic                   pcm_serial_output_oe
);
	import psa_pkg::*;

	// Slot match of a position: {first byte, second byte}
	function automatic logic [1:0] slot_hit(psa_slot_s s, logic lin, logic [BIT_POS_W-1:0] pos);
		logic [7:0] idx;
		idx = {1'b0, pos[BIT_POS_W-1:3]};
		slot_hit[1] = s.en && (idx == {1'b0, s.num});
		slot_hit[0] = s.en && lin && (idx == ({1'b0, s.num} + 8'h01));
	endfunction

	// Register index of an address inside a group
	function automatic logic [1:0] group_index(logic [7:0] addr, logic [7:0] base);
		logic [7:0] diff;
		diff = addr - base;
		group_index = diff[1:0];
	endfunction

	// ---------------- System domain ----------------
	logic [3:1][7:0]   tx_slot_reg;
	logic [3:0][7:0]   rx_slot_reg;
	logic [7:0]        ins_low;
	logic [7:0]        ins_high;
	logic [7:0]        cap_low;
	logic [7:0]        cap_high;
	logic              low_seen;
	logic              irq_wr;
	logic              irq_rd;
	psa_samples_t      tx_bundle;
	logic              fev_s1;
	logic              fev_s2;
	logic              fev_s3;
	logic              frame_tgl;
	psa_cfg_s          cfg_sys;
	psa_cfg_s          cfg_hold;

	wire frame_evt  = fev_s2 ^ fev_s3;
	wire in_tx      = reg_addr >= ADDR_TX_SLOT_CH1 && reg_addr <= ADDR_TX_SLOT_CH3;
	wire in_rx      = reg_addr >= ADDR_RX_SLOT_CH0 && reg_addr <= ADDR_RX_SLOT_CH3;
	wire [1:0] tx_idx = group_index(reg_addr, ADDR_TX_SLOT_CH1) + 2'd1;
	wire [1:0] rx_idx = group_index(reg_addr, ADDR_RX_SLOT_CH0);
	wire ins_wr     = reg_wr && (reg_addr == ADDR_INSERT_LOW || reg_addr == ADDR_INSERT_HIGH);
	wire cap_rd_lo  = reg_rd && reg_addr == ADDR_CAPTURE_LOW;
	wire cap_rd_hi  = reg_rd && reg_addr == ADDR_CAPTURE_HIGH;
	// ready clears on high read after low
	wire rd_done    = cap_rd_hi && low_seen;
	wire wr_evt     = frame_evt && access_cfg.wr_en;
	wire rd_evt     = frame_evt && access_cfg.rd_en;

	// Readback mux; unmapped addresses answer zero
	wire [7:0] rd_mux =
		in_tx ? tx_slot_reg[tx_idx] :
		in_rx ? rx_slot_reg[rx_idx] :
		reg_addr == ADDR_INSERT_LOW   ? ins_low :
		reg_addr == ADDR_INSERT_HIGH  ? ins_high :
		reg_addr == ADDR_CAPTURE_LOW  ? cap_low :
		reg_addr == ADDR_CAPTURE_HIGH ? cap_high : UNMAPPED_READ;

	// a frame sets wait and interrupt; set beats clear
	wire next_write_wait = wr_evt | (access_status.write_wait & ~ins_wr);
	wire next_irq_wr     = wr_evt | (irq_wr & ~ins_wr & access_cfg.wr_en);
	wire next_irq_rd     = rd_evt | (irq_rd & ~(cap_rd_lo | cap_rd_hi) & access_cfg.rd_en);
	wire next_miss_wr    = access_cfg.wr_en &
		(access_status.missed_write | (wr_evt & access_status.write_wait & ~ins_wr));
	// no full read since last frame
	wire next_miss_rd    = access_cfg.rd_en &
		(access_status.missed_read | (rd_evt & access_status.read_ready & ~rd_done));
	wire next_read_ready = rd_evt | (access_status.read_ready & ~rd_done);

	// companded coding only uses the low byte
	wire [15:0] ins_word = linear_mode ? {ins_high, ins_low} : {REG_RESET, ins_low};
	wire [15:0] cap_src  = tx_sample[access_cfg.ch];

	// Link-side results, stable for a whole frame when sampled
	psa_samples_t  rx_hold;
	logic [3:0]    rx_got;

	// Register file
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_slot_reg <= '0;
			rx_slot_reg <= '0;
			ins_low     <= REG_RESET;
			ins_high    <= REG_RESET;
			reg_rdata   <= REG_RESET;
		end else if (ce) begin
			if (reg_wr && in_tx)
				tx_slot_reg[tx_idx] <= reg_wdata;
			if (reg_wr && in_rx)
				rx_slot_reg[rx_idx] <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_INSERT_LOW)
				ins_low <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_INSERT_HIGH)
				ins_high <= reg_wdata;
			if (reg_rd)
				reg_rdata <= rd_mux;
		end
	end

	// Access flags, capture buffer and interrupt
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			access_status           <= '0;
			irq_wr                  <= 1'b0;
			irq_rd                  <= 1'b0;
			sample_access_interrupt <= 1'b0;
			low_seen                <= 1'b0;
			cap_low                 <= REG_RESET;
			cap_high                <= REG_RESET;
		end else if (ce) begin
			access_status.write_wait   <= next_write_wait;
			access_status.missed_write <= next_miss_wr;
			access_status.read_ready   <= next_read_ready;
			access_status.missed_read  <= next_miss_rd;
			irq_wr                     <= next_irq_wr;
			irq_rd                     <= next_irq_rd;
			sample_access_interrupt    <= next_irq_wr | next_irq_rd;
			// low byte read arms the high read
			if (cap_rd_lo)
				low_seen <= 1'b1;
			else if (cap_rd_hi || rd_evt)
				low_seen <= 1'b0;
			if (rd_evt) begin
				cap_low  <= cap_src[7:0];
				cap_high <= linear_mode ? cap_src[15:8] : REG_RESET;
			end
		end
	end

	// Frame event crossing and sample exchange
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fev_s1    <= 1'b0;
			fev_s2    <= 1'b0;
			fev_s3    <= 1'b0;
			tx_bundle <= '0;
			cfg_hold  <= '0;
			rx_sample <= '0;
			rx_valid  <= '0;
		end else if (ce) begin
			fev_s1 <= frame_tgl;
			fev_s2 <= fev_s1;
			fev_s3 <= fev_s2;
			rx_valid <= '0;
			if (frame_evt) begin
				// Updated just after a frame start, read by the link at the next one
				tx_bundle <= tx_sample;
				cfg_hold  <= cfg_sys;
				for (int ch = 0; ch < CH_N; ch++) begin
					// insert buffer replaces selected channel, old value reused
					if (access_cfg.wr_en && access_cfg.ch == 2'(ch)) begin
						rx_sample[ch] <= ins_word;
						rx_valid[ch]  <= 1'b1;
					end else begin
						rx_sample[ch] <= rx_hold[ch];
						rx_valid[ch]  <= rx_got[ch];
					end
				end
			end
		end
	end

	// Configuration bundle, handed over through cfg_hold like the samples
	always_comb begin
		cfg_sys.tx[0] = psa_slot_s'(tx_slot_ch0);
		cfg_sys.tx[1] = psa_slot_s'(tx_slot_reg[1]);
		cfg_sys.tx[2] = psa_slot_s'(tx_slot_reg[2]);
		cfg_sys.tx[3] = psa_slot_s'(tx_slot_reg[3]);
		for (int ch = 0; ch < CH_N; ch++)
			cfg_sys.rx[ch] = psa_slot_s'(rx_slot_reg[ch]);
		cfg_sys.linear = linear_mode;
	end

	// ---------------- Link domain ----------------
	psa_cfg_s               cfg;
	logic                   fs_d;
	logic [BIT_POS_W-1:0]   bit_pos;
	psa_samples_t           tx_shadow;
	psa_samples_t           rx_shift;
	psa_samples_t           next_rx_shift;
	logic [3:0]             rx_seen;
	logic [3:0]             rx_take;
	logic                   next_dx;
	logic                   next_oe;
	logic [1:0]             tx_h;
	logic [15:0]            tx_word;
	logic [7:0]             tx_byte;

	wire fs_rise = pcm_fs & ~fs_d;
	// position counted from the frame start
	wire [BIT_POS_W-1:0] next_pos = fs_rise ? '0 : bit_pos + 10'd1;
	// Bundle is stable here: it changed a few clocks after the previous frame start
	wire psa_samples_t tx_cur = fs_rise ? tx_bundle : tx_shadow;
	wire psa_cfg_s     cfg_cur = fs_rise ? cfg_hold : cfg;

	// Serial output for the bit that starts at this edge
	always_comb begin
		next_dx = 1'b0;
		next_oe = 1'b0;
		tx_h    = 2'b00;
		tx_word = '0;
		tx_byte = '0;
		// Lowest channel wins when slots collide
		for (int ch = CH_N - 1; ch >= 0; ch--) begin
			// disabled slot never matches, output stays off
			tx_h = slot_hit(cfg_cur.tx[ch], cfg_cur.linear, next_pos);
			if (|tx_h) begin
				tx_word = tx_cur[ch];
				// high byte first slot, low byte following slot
				tx_byte = (tx_h[1] && cfg_cur.linear) ? tx_word[15:8] : tx_word[7:0];
				next_dx = tx_byte[~next_pos[2:0]];
				next_oe = 1'b1;
			end
		end
	end

	// Receive slot capture at the current bit
	always_comb begin
		for (int ch = 0; ch < CH_N; ch++) begin
			// disabled receive slot is never taken
			rx_take[ch]       = |slot_hit(cfg.rx[ch], cfg.linear, bit_pos);
			next_rx_shift[ch] = rx_take[ch] ? {rx_shift[ch][14:0], pcm_serial_input} : rx_shift[ch];
		end
	end

	always_ff @(posedge pcm_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg                  <= '0;
			fs_d                 <= 1'b0;
			bit_pos              <= '0;
			frame_tgl            <= 1'b0;
			tx_shadow            <= '0;
			rx_shift             <= '0;
			rx_seen              <= '0;
			rx_hold              <= '0;
			rx_got               <= '0;
			pcm_serial_output    <= 1'b0;
			pcm_serial_output_oe <= 1'b0;
		end else begin
			fs_d                 <= pcm_fs;
			bit_pos              <= next_pos;
			pcm_serial_output    <= next_dx;
			pcm_serial_output_oe <= next_oe;
			if (fs_rise) begin
				tx_shadow <= tx_bundle;
				// Frame-aligned load: no torn word, no cut slot
				cfg       <= cfg_hold;
				frame_tgl <= ~frame_tgl;
				rx_shift  <= '0;
				rx_seen   <= '0;
				rx_got    <= rx_seen | rx_take;
				// linear keeps both bytes, companded only the low one
				for (int ch = 0; ch < CH_N; ch++)
					rx_hold[ch] <= cfg.linear ? next_rx_shift[ch]
						: {REG_RESET, next_rx_shift[ch][7:0]};
			end else begin
				rx_shift <= next_rx_shift;
				rx_seen  <= rx_seen | rx_take;
			end
		end
	end

endmodule

// ===== inc/psa_pkg.sv
// Constants and carrier types for the PCM slot assignment and sample access block
package psa_pkg;

	// Register addresses on the register port
	localparam logic [7:0] ADDR_TX_SLOT_CH1  = 8'h53;
	localparam logic [7:0] ADDR_TX_SLOT_CH2  = 8'h54;
	localparam logic [7:0] ADDR_TX_SLOT_CH3  = 8'h55;
	localparam logic [7:0] ADDR_RX_SLOT_CH0  = 8'h56;
	localparam logic [7:0] ADDR_RX_SLOT_CH1  = 8'h57;
	localparam logic [7:0] ADDR_RX_SLOT_CH2  = 8'h58;
	localparam logic [7:0] ADDR_RX_SLOT_CH3  = 8'h59;
	localparam logic [7:0] ADDR_INSERT_LOW   = 8'h5A;
	localparam logic [7:0] ADDR_INSERT_HIGH  = 8'h5B;
	localparam logic [7:0] ADDR_CAPTURE_LOW  = 8'h5C;
	localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'h5D;

	// Reset value of every register and buffer
	localparam logic [7:0] REG_RESET = 8'h00;
	// Value returned for an unmapped address
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Field layout of a slot register: enable in bit 7, slot number in bits 6..0
	localparam int SLOT_EN_POS  = 7;
	localparam int SLOT_NUM_W   = 7;
	localparam int CH_N         = 4;
	localparam int BIT_POS_W    = 10;
	localparam int BYTE_BITS    = 8;

	typedef struct packed {
		logic                  en;
		logic [SLOT_NUM_W-1:0] num;
	} psa_slot_s;

	typedef struct packed {
		psa_slot_s [CH_N-1:0] tx;
		psa_slot_s [CH_N-1:0] rx;
		logic                 linear;
	} psa_cfg_s;

	typedef logic [CH_N-1:0][15:0] psa_samples_t;

	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [1:0] ch;
	} psa_access_s;

	typedef struct packed {
		logic missed_write;
		logic missed_read;
		logic write_wait;
		logic read_ready;
	} psa_status_s;

endpackage

// ===== bench/psa_pcm_slot_access_chk.sv
// Concurrent checks on the ports of the PCM slot access block
module psa_pcm_slot_access_chk (
	// Clocks and reset
	input wire logic                 clk,
	input wire logic                 sys_rst,
	input wire logic                 pcm_clk,
	// Register port
	input wire logic                 ce,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire logic [7:0]           reg_addr,
	// Status and highway
	input wire psa_pkg::psa_access_s access_cfg,
	input wire psa_pkg::psa_status_s access_status,
	input wire logic                 sample_access_interrupt,
	input wire logic [3:0]           rx_valid,
	input wire logic                 pcm_serial_output,
	input wire logic                 pcm_serial_output_oe
);
	import psa_pkg::*;
	wire ins_wr = ce && reg_wr &&
		(reg_addr == ADDR_INSERT_LOW || reg_addr == ADDR_INSERT_HIGH);
	wire hi_rd = ce && reg_rd && reg_addr == ADDR_CAPTURE_HIGH;

	a_oe_data_zero: assert property (@(posedge pcm_clk) disable iff (sys_rst)
		!pcm_serial_output_oe |-> !pcm_serial_output) else $error("data high while undriven");
	a_oe_slot_len: assert property (@(posedge pcm_clk) disable iff (sys_rst)
		$rose(pcm_serial_output_oe) |-> pcm_serial_output_oe[*8]) else $error("short slot");
	a_wait_sets_int: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(access_status.write_wait) |-> sample_access_interrupt) else $error("no interrupt");
	a_ready_sets_int: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(access_status.read_ready) |-> sample_access_interrupt) else $error("no interrupt");
	a_wait_clear_cause: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(access_status.write_wait) |-> $past(ins_wr)) else $error("wait cleared alone");
	a_ready_clear_cause: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(access_status.read_ready) |-> $past(hi_rd)) else $error("ready cleared alone");
	a_rx_valid_pulse: assert property (@(posedge clk) disable iff (sys_rst)
		rx_valid != 4'h0 |=> rx_valid == 4'h0) else $error("valid held");
	a_missed_wr_clear: assert property (@(posedge clk) disable iff (sys_rst)
		ce && !access_cfg.wr_en |=> !access_status.missed_write)
		else $error("missed write stuck");
	a_missed_rd_clear: assert property (@(posedge clk) disable iff (sys_rst)
		ce && !access_cfg.rd_en |=> !access_status.missed_read)
		else $error("missed read stuck");

	c_ready: cover property (@(posedge clk) $rose(access_status.read_ready));
	c_missed: cover property (@(posedge clk) $rose(access_status.missed_write));
	c_slot: cover property (@(posedge pcm_clk) $rose(pcm_serial_output_oe));
endmodule

bind psa_pcm_slot_access psa_pcm_slot_access_chk u_chk (.clk, .sys_rst, .pcm_clk, .ce,
	.reg_wr, .reg_rd, .reg_addr, .access_cfg, .access_status, .sample_access_interrupt,
	.rx_valid, .pcm_serial_output, .pcm_serial_output_oe);

// ===== bench/psa_hwy_model.sv
// Highway framer model: bit clock, frame sync, receive data, transmit capture
module psa_hwy_model (
	// Highway lines
	output logic      pcm_clk,
	output logic      pcm_fs,
	output logic      pcm_serial_input,
	input  wire logic pcm_serial_output,
	input  wire logic pcm_serial_output_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	// Starts near a wrap so the first frame follows reset soon
	logic [9:0] bp = 10'h3F0;
	int         frames = 0;
	logic       cap_d [1024];
	logic       cap_oe [1024];
	logic [7:0] cur;
	logic       fs_q = 1'b0;

	function automatic logic [7:0] pat(input int s);
		return 8'hC3 ^ 8'(s);
	endfunction

	// Free running bit clock, phase unrelated to the system clock
	initial begin
		pcm_clk = 1'h0;
		#7;
		forever #15 pcm_clk = ~pcm_clk;
	end

	// slot n on bits 8n..8n+7, MSB first
	assign pcm_fs = fs_q;
	assign cur = pat(int'(bp[9:3]));
	assign pcm_serial_input = cur[3'h7 - bp[2:0]];

	always @(posedge pcm_clk) begin
		cap_d[bp] <= pcm_serial_output;
		cap_oe[bp] <= pcm_serial_output_oe;
		fs_q <= (bp == 10'h3FE);
		bp <= bp + 10'h001;
		if (bp == 10'h3FF)
			frames <= frames + 1;
	end
endmodule

// ===== bench/psa_pcm_slot_access_tb.sv
// Self-checking bench for the PCM slot access block
module psa_pcm_slot_access_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import psa_pkg::*;
	logic         clk = 1'h0;
	logic         sys_rst = 1'h1;
	logic         ce = 1'h1;
	logic         reg_wr = 1'h0;
	logic         reg_rd = 1'h0;
	logic [7:0]   reg_addr = 8'h00;
	logic [7:0]   reg_wdata = 8'h00;
	logic [7:0]   reg_rdata;
	logic [7:0]   tx_slot_ch0 = 8'h94;
	logic         linear_mode = 1'h0;
	psa_access_s  access_cfg = 4'h0;
	psa_samples_t tx_sample = {16'h005A, 16'h0000, 16'h00A5, 16'h0033};
	psa_samples_t rx_sample;
	logic [3:0]   rx_valid;
	psa_status_s  access_status;
	logic         sample_access_interrupt;
	logic         pcm_clk, pcm_fs, pcm_serial_input;
	logic         pcm_serial_output, pcm_serial_output_oe;
	int           err_count = 0;
	int           n_tests = 0;
	int           vc0 = 0;
	int           vc1 = 0;

	always #10 clk = ~clk;
	always @(posedge clk) begin
		vc0 <= vc0 + int'(rx_valid[0]);
		vc1 <= vc1 + int'(rx_valid[1]);
	end

	psa_pcm_slot_access DUT (.clk, .sys_rst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .tx_slot_ch0, .linear_mode, .access_cfg, .tx_sample, .rx_sample,
		.rx_valid, .access_status, .sample_access_interrupt, .pcm_clk, .pcm_fs,
		.pcm_serial_input, .pcm_serial_output, .pcm_serial_output_oe);
	psa_hwy_model hwy (.pcm_clk, .pcm_fs, .pcm_serial_input, .pcm_serial_output,
		.pcm_serial_output_oe);

	task automatic test_done;
		$display("mismatches %0d of %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'h1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_rd = 1'h1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'h0;
		chk(16'(reg_rdata), 16'(exp));
	endtask

	// Bounded wait for n frame starts; early bits of the new frame get overwritten
	task automatic frame(input int n);
		int f;
		f = hwy.frames + n;
		for (int i = 0; i < 5000 * n && hwy.frames < f; i++)
			@(negedge clk);
		if (hwy.frames < f) begin
			err_count++;
			test_done();
		end
	endtask

	task automatic slot(input int s, input logic [7:0] d, input logic oe);
		for (int b = 0; b < 8; b++) begin
			chk(16'(hwy.cap_oe[8*s+b]), 16'(oe));
			if (oe)
				chk(16'(hwy.cap_d[8*s+b]), 16'(d[7-b]));
		end
	endtask

	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'h0;
		for (int a = 8'h53; a <= 8'h5D; a++)
			rd(8'(a), REG_RESET);
		frame(1);
		wr(ADDR_TX_SLOT_CH1, 8'h85);
		wr(ADDR_TX_SLOT_CH2, 8'h09);
		wr(ADDR_TX_SLOT_CH3, 8'hFF);
		wr(ADDR_RX_SLOT_CH0, 8'h85);
		wr(ADDR_RX_SLOT_CH1, 8'h09);
		wr(ADDR_CAPTURE_LOW, 8'h77);
		ce = 1'h0;
		wr(ADDR_RX_SLOT_CH3, 8'hAA);
		ce = 1'h1;
		rd(ADDR_TX_SLOT_CH1, 8'h85);
		rd(8'h60, UNMAPPED_READ);
		rd(ADDR_TX_SLOT_CH2, 8'h09);
		rd(ADDR_TX_SLOT_CH3, 8'hFF);
		rd(ADDR_RX_SLOT_CH1, 8'h09);
		rd(ADDR_RX_SLOT_CH3, 8'h00);
		rd(ADDR_CAPTURE_LOW, 8'h00);
		frame(3);
		slot(5, 8'hA5, 1'h1);
		slot(9, 8'h00, 1'h0);
		slot(20, 8'h33, 1'h1);
		slot(127, 8'h5A, 1'h1);
		repeat (8) @(negedge clk);
		chk(16'(rx_sample[0][7:0]), 16'(hwy.pat(5)));
		chk(16'(vc1), 16'h0000);
		chk(16'(vc0 > 0), 16'h0001);
		frame(1);
		linear_mode = 1'h1;
		tx_sample[1] = 16'h9C3E;
		frame(3);
		slot(5, 8'h9C, 1'h1);
		slot(6, 8'h3E, 1'h1);
		repeat (8) @(negedge clk);
		chk(rx_sample[0], {hwy.pat(5), hwy.pat(6)});
		access_cfg = 4'hD;
		frame(1);
		repeat (8) @(negedge clk);
		chk(16'(access_status), 16'h0003);
		chk(16'(sample_access_interrupt), 16'h0001);
		wr(ADDR_INSERT_LOW, 8'h11);
		wr(ADDR_INSERT_HIGH, 8'h22);
		@(negedge clk);
		chk(16'(access_status), 16'h0001);
		chk(16'(sample_access_interrupt), 16'h0001);
		rd(ADDR_CAPTURE_LOW, 8'h3E);
		chk(16'(access_status), 16'h0001);
		rd(ADDR_CAPTURE_HIGH, 8'h9C);
		@(negedge clk);
		chk(16'(access_status), 16'h0000);
		chk(16'(sample_access_interrupt), 16'h0000);
		frame(1);
		repeat (8) @(negedge clk);
		chk(rx_sample[1], 16'h2211);
		tx_sample[1] = 16'h4D2B;
		frame(1);
		repeat (8) @(negedge clk);
		chk(16'(access_status), 16'h000F);
		chk(rx_sample[1], 16'h2211);
		rd(ADDR_CAPTURE_LOW, 8'h2B);
		access_cfg = 4'h0;
		repeat (4) @(negedge clk);
		chk(16'(access_status[3:2]), 16'h0000);
		test_done();
	end
endmodule
